// *** sim/msq_sys_model.sv ***
// System side model: enable lines, hold, thermal flag, switching events.
`timescale 1ns/100ps
module msq_sys_model (
	input  wire       ref_clk,
	input  wire [2:0] want_en,
	input  wire       want_hold,
	input  wire       want_therm,
	input  wire       dual,
	input  wire [2:0] skip_go,
	input  wire [2:0] wake_go,
	output reg        channel_a_enable = 1'b0,
	output reg        phase_b_enable = 1'b0,
	output reg        phase_c_enable = 1'b0,
	output reg        hold_request = 1'b0,
	output reg        therm_over = 1'b0,
	output reg  [2:0] hs_skip_evt = 3'h0,
	output reg  [2:0] hs_switch_evt = 3'h0
);
	// Lines move together on one edge; phase C may only rise in dual mode
	// while B runs, so a request for both brings C up one cycle later.
	always @(posedge ref_clk) begin
		channel_a_enable <= want_en[0];
		phase_b_enable <= want_en[1];
		phase_c_enable <= want_en[2] && (!dual || phase_c_enable ||
			(phase_b_enable && want_en[1]));
		hold_request <= want_hold;
		therm_over <= want_therm;
		hs_skip_evt <= skip_go;
		hs_switch_evt <= wake_go;
	end
endmodule // msq_sys_model

// *** sim/msq_top_properties.sv ***
// Port checker for the mode sequencer, bound onto the top module.
`timescale 1ns/100ps
`include "msq_regs.vh"
module msq_props (
	input wire              ref_clk,
	input wire              srst,
	input wire              channel_a_enable,
	input wire              phase_b_enable,
	input wire              phase_c_enable,
	input wire              hold_request,
	input wire              therm_over,
	input wire [2:0]        channel_on,
	input wire              osc_run,
	input wire              supply_reg_en,
	input wire              charge_pump_en,
	input wire              overload_prot_en,
	input wire [1:0]        overload_mode,
	input wire [1:0]        vout_sel,
	input wire              phase_c_tied,
	input wire              phase_c_power_good_en,
	input wire              batt_mon_en,
	input wire              batt_mon_output_oe,
	input wire              s_axi_arvalid,
	input wire              s_axi_arready,
	input wire              s_axi_rvalid,
	input wire              s_axi_rready,
	input wire              s_axi_bvalid,
	input wire              s_axi_bready
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// Eight idle cycles outlast the synchroniser plus the output lag.
	wire idle = !channel_a_enable && !phase_b_enable && !phase_c_enable &&
		!hold_request;
	a_therm_stop: assert property (therm_over [*8] |->
		channel_on == 3'h0 && !supply_reg_en && !osc_run)
		else $error("Outputs alive while overheated.");
	a_idle_shut: assert property (idle [*8] |->
		channel_on == 3'h0 && !supply_reg_en && !overload_prot_en)
		else $error("Outputs alive with every request low.");
	a_pump_boost: assert property (charge_pump_en |->
		!batt_mon_en && supply_reg_en && osc_run)
		else $error("Charge pump outside boost activity.");
	a_dual_gate: assert property (phase_c_tied &&
		channel_on[2] |-> channel_on[1])
		else $error("Phase C runs without phase B.");
	a_pgood_dual: assert property (phase_c_tied |->
		!phase_c_power_good_en)
		else $error("Phase C power good active in dual mode.");
	a_guard_active: assert property (overload_prot_en |->
		channel_on != 3'h0 && osc_run)
		else $error("Overload guard without a running channel.");
	a_pull_cause: assert property (
		batt_mon_output_oe |-> batt_mon_en || charge_pump_en)
		else $error("Monitor pin pulled with no owner.");
	a_cfg_hold: assert property (channel_on != 3'h0 &&
		$past(channel_on) != 3'h0 |-> $stable(vout_sel) &&
		$stable(overload_mode) && $stable(phase_c_tied))
		else $error("Captured configuration moved while running.");
	a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid)
		else $error("Read answer late.");
	a_write_end: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid)
		else $error("Write answer not withdrawn.");
	cover property (therm_over [*8]);
	cover property (charge_pump_en && phase_c_tied);
	cover property ($fell(osc_run) && supply_reg_en);
endmodule // msq_props

bind msq_top msq_props chk_u (.ref_clk, .srst, .channel_a_enable,
	.phase_b_enable, .phase_c_enable, .hold_request, .therm_over,
	.channel_on, .osc_run, .supply_reg_en, .charge_pump_en,
	.overload_prot_en, .overload_mode, .vout_sel, .phase_c_tied,
	.phase_c_power_good_en, .batt_mon_en, .batt_mon_output_oe,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_bvalid, .s_axi_bready);

// *** sim/msq_top_tb.sv ***
// Self-checking bench for the multirail mode sequencer.
`timescale 1ns/100ps
`include "msq_regs.vh"
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin \
	mismatches++; $display("CHECK FAILED at %0t: %s", $time, m); end end
module msq_top_tb;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic batt_mon_fixed_input = 1'b0, batt_mon_prog_input = 1'b0;
	logic supply_lost = 1'b0, strap_boost = 1'b0;
	logic strap_dual_phase = 1'b0, strap_skip_mode = 1'b0;
	logic [1:0] overload_restart_select = 2'h0, strap_vout_sel = 2'h0;
	logic [2:0] want_en = 3'h0, skip_go = 3'h0, wake_go = 3'h0;
	logic want_hold = 1'b0, want_therm = 1'b0;
	logic [`MSQ_AW-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [`MSQ_DW-1:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire channel_a_enable, phase_b_enable, phase_c_enable;
	wire hold_request, therm_over, osc_run, supply_reg_en, charge_pump_en;
	wire overload_prot_en, phase_c_tied, phase_c_power_good_en;
	wire batt_mon_en, batt_mon_output_o, batt_mon_output_oe;
	wire [2:0] hs_skip_evt, hs_switch_evt, channel_on;
	wire [1:0] overload_mode, vout_sel, s_axi_bresp, s_axi_rresp;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire s_axi_arready, s_axi_rvalid;
	wire [`MSQ_DW-1:0] s_axi_rdata;
	int mismatches = 0, samples_checked = 0;
	// Reference model state: mode code and the captured straps.
	int mode = 0;
	bit m_boost, m_dual, m_skip, ctrl_mon = 1'b1;
	bit [1:0] m_ovl, m_vsel;

	initial forever #50 ref_clk = ~ref_clk;

	msq_sys_model sys_u (.ref_clk, .want_en, .want_hold, .want_therm,
		.dual(strap_dual_phase), .skip_go, .wake_go, .channel_a_enable,
		.phase_b_enable, .phase_c_enable, .hold_request, .therm_over,
		.hs_skip_evt, .hs_switch_evt);
	msq_top #(.CFG_CYCLES(2)) dut_u (.ref_clk, .srst, .channel_a_enable,
		.phase_b_enable, .phase_c_enable, .hold_request, .therm_over,
		.batt_mon_fixed_input, .batt_mon_prog_input, .supply_lost,
		.strap_boost, .strap_dual_phase, .strap_skip_mode,
		.overload_restart_select, .strap_vout_sel, .hs_skip_evt,
		.hs_switch_evt, .channel_on, .osc_run, .supply_reg_en,
		.charge_pump_en, .overload_prot_en, .overload_mode, .vout_sel,
		.phase_c_tied, .phase_c_power_good_en, .batt_mon_en,
		.batt_mon_output_o, .batt_mon_output_oe, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	// Prints the verdict and ends the run.
	task automatic final_report;
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One clock of a bus wait; a wait that runs too long ends the run.
	task automatic tick(inout int n);
		@(posedge ref_clk);
		n++;
		if (n > 200) begin
			mismatches++;
			$display("CHECK FAILED at %0t: bus wait ran out", $time);
			final_report();
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
			output logic [1:0] r);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			tick(n);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
			output logic [1:0] r);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			tick(n);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge ref_clk);
	endtask

	// Applies requests, waits out sync, configuration and output lag
	// (14 cycles), advances the model and compares the outputs, osc_run outside hold, tie and straps in active or hold.
	task automatic step(input logic [2:0] en, input logic hold);
		logic [31:0] d;
		logic [1:0] r;
		logic [2:0] e, ch;
		bit act, mon;
		want_en <= en;
		want_hold <= hold;
		batt_mon_fixed_input <= 1'($urandom);
		batt_mon_prog_input <= 1'($urandom);
		repeat (14) @(posedge ref_clk);
		e = {phase_c_enable, phase_b_enable, channel_a_enable};
		if (want_therm) mode = 5;
		else if (supply_lost || (e == 3'h0 && !hold)) mode = 0;
		else begin
			if (mode == 0 || mode == 5) begin
				{m_vsel, m_ovl} = {strap_vout_sel, overload_restart_select};
				{m_skip, m_dual, m_boost} =
					{strap_skip_mode, strap_dual_phase, strap_boost};
			end
			mode = (e != 3'h0) ? 2 : 4;
		end
		act = (mode == 2);
		ch = act ? {e[2] & (e[1] | !m_dual), e[1:0]} : 3'h0;
		mon = !m_boost && ctrl_mon && (act || mode >= 4);
		`CHK(channel_on, ch, "channel run")
		`CHK(supply_reg_en, act || mode == 4, "supply")
		if (mode != 4) `CHK(osc_run, act, "oscillator")
		`CHK(charge_pump_en, act && m_boost, "pump")
		`CHK(overload_prot_en, act && ch != 3'h0, "guard")
		`CHK(batt_mon_en, mon, "monitor on")
		`CHK(batt_mon_output_oe, m_boost ? act : mon &&
			!batt_mon_prog_input && batt_mon_fixed_input, "pull")
		`CHK(batt_mon_output_o, 1'b0, "pin level")
		`CHK(phase_c_power_good_en, act && !m_dual && e[2], "pg")
		axi_rd(8'h04, d, r);
		`CHK(d[6:4], mode[2:0], "mode code")
		if (act || mode == 4) begin
			`CHK(phase_c_tied, m_dual, "tie")
			`CHK({vout_sel, overload_mode}, {m_vsel, m_ovl}, "held")
			axi_rd(8'h08, d, r);
			`CHK(d[6:0], {m_vsel, m_ovl, m_skip, m_dual, m_boost},
				"captured")
		end
	endtask

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		void'($urandom(32'h222c8cc0));
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		axi_rd(8'h00, d, r);
		`CHK(d[1:0], 2'h3, "ctrl reset")
		step(3'h0, 1'b0);
		// Every topology pairing, with straps moved while running.
		for (int i = 0; i < 4; i++) begin
			strap_boost <= i[0];
			strap_dual_phase <= i[1];
			strap_skip_mode <= 1'b1;
			overload_restart_select <= 2'($urandom);
			strap_vout_sel <= 2'($urandom);
			step(3'h1 | 3'($urandom), 1'b0);
			strap_vout_sel <= ~strap_vout_sel;
			step(3'h7, 1'b0);
			step(3'h3, 1'b0);
			step(3'h5, 1'b0);
			step(3'h0, 1'b1);
			step(3'h2, 1'b0);
			step(3'h0, 1'b0);
		end
		// Register refusals and the monitor allow bit on a buck part.
		strap_boost <= 1'b0;
		strap_dual_phase <= 1'b0;
		step(3'h1, 1'b0);
		axi_wr(8'h00, 32'h1, r);
		ctrl_mon = 1'b0;
		`CHK(r, 2'h0, "ctrl write")
		step(3'h1, 1'b0);
		axi_wr(8'h04, 32'hFF, r);
		`CHK(r, 2'h2, "status write")
		axi_rd(8'h0C, d, r);
		`CHK({r, d}, {2'h2, 32'h0}, "unmapped")
		axi_wr(8'h00, 32'h3, r);
		ctrl_mon = 1'b1;
		// Overheat from active, then restart with fresh straps.
		want_therm <= 1'b1;
		step(3'h1, 1'b0);
		want_therm <= 1'b0;
		strap_vout_sel <= ~strap_vout_sel;
		step(3'h1, 1'b0);
		// A lost supply shuts down and forces a fresh strap capture.
		supply_lost <= 1'b1;
		step(3'h1, 1'b0);
		supply_lost <= 1'b0;
		strap_vout_sel <= ~strap_vout_sel;
		step(3'h1, 1'b0);
		// Fifteen skips keep the channel awake; the sixteenth sleeps it.
		skip_go <= 3'h1;
		repeat (15) @(posedge ref_clk);
		skip_go <= 3'h0;
		repeat (8) @(posedge ref_clk);
		axi_rd(8'h04, d, r);
		`CHK({d[11], d[6:4]}, 4'h2, "awake at 15")
		skip_go <= 3'h1;
		@(posedge ref_clk);
		skip_go <= 3'h0;
		repeat (8) @(posedge ref_clk);
		axi_rd(8'h04, d, r);
		`CHK({d[11], d[6:4]}, 4'hB, "deep sleep")
		`CHK({osc_run, overload_prot_en}, 2'h0, "stopped")
		wake_go <= 3'h1;
		@(posedge ref_clk);
		wake_go <= 3'h0;
		step(3'h1, 1'b0);
		step(3'h0, 1'b0);
		final_report();
	end
endmodule // msq_top_tb

// *** verilog/msq_regs.vh ***
// Constants for the multirail mode sequencer: states, map, fields, counts.
`ifndef MSQ_REGS_VH
`define MSQ_REGS_VH
`define MSQ_ST_W 3
`define MSQ_ST_SHUT 3'h0
`define MSQ_ST_CFG 3'h1
`define MSQ_ST_ACT 3'h2
`define MSQ_ST_DEEP 3'h3
`define MSQ_ST_HOLD 3'h4
`define MSQ_ST_THERM 3'h5
`define MSQ_DW 32
`define MSQ_AW 8
`define MSQ_OFF_CTRL 8'h00
`define MSQ_OFF_STAT 8'h04
`define MSQ_OFF_CONF 8'h08
`define MSQ_SEL_W 2
`define MSQ_SEL_NONE 2'h0
`define MSQ_SEL_CTRL 2'h1
`define MSQ_SEL_STAT 2'h2
`define MSQ_SEL_CONF 2'h3
`define MSQ_CTRL_W 2
`define MSQ_CTRL_RST 2'h3
`define MSQ_CTRL_DEEP 0
`define MSQ_CTRL_MON 1
`define MSQ_STAT_W 16
`define MSQ_CONF_W 7
`define MSQ_RESP_OK 2'h0
`define MSQ_RESP_ERR 2'h2
`define MSQ_SKIP_CYC 5'h10
`define MSQ_SKIP_W 5
`define MSQ_SY_W 15
`define MSQ_CFG_CYC 8
`endif

// *** verilog/msq_skip_cnt.v ***
// Per-channel skip counter that marks a buck channel asleep.
`timescale 1ns/100ps
`include "msq_regs.vh"
module msq_skip_cnt (
	input  wire ref_clk,
	input  wire srst,
	input  wire allow,
	input  wire skip_evt,
	input  wire sw_evt,
	output wire asleep
);
	reg [`MSQ_SKIP_W-1:0] cnt_reg;
	reg                   sleep_reg;

	// A real switching cycle breaks the run and wakes the channel.
	always @(posedge ref_clk) begin
		if (srst || !allow || sw_evt) begin
			cnt_reg   <= {`MSQ_SKIP_W{1'b0}};
			sleep_reg <= 1'b0;
		end else if (skip_evt && !sleep_reg) begin
			if (cnt_reg == `MSQ_SKIP_CYC - 5'h01)
				sleep_reg <= 1'b1;
			cnt_reg <= cnt_reg + 5'h01;
		end
	end
	assign asleep = sleep_reg;
endmodule // msq_skip_cnt

// *** verilog/msq_sync.v ***
// Three-stage input synchroniser that accepts a change once stages agree.
`timescale 1ns/100ps
module msq_sync #(
	parameter W = 1
) (
	input  wire         ref_clk,
	input  wire         srst,
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);
	reg [W-1:0] s1_reg;
	reg [W-1:0] s2_reg;
	reg [W-1:0] s3_reg;
	reg [W-1:0] out_reg;
	genvar i;

	// Stage one feeds only stage two; a bit moves once two and three agree.
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge ref_clk) begin
				if (srst) begin
					s1_reg[i]  <= 1'b0;
					s2_reg[i]  <= 1'b0;
					s3_reg[i]  <= 1'b0;
					out_reg[i] <= 1'b0;
				end else begin
					s1_reg[i] <= async_in[i];
					s2_reg[i] <= s1_reg[i];
					s3_reg[i] <= s2_reg[i];
					if (s2_reg[i] == s3_reg[i])
						out_reg[i] <= s3_reg[i];
				end
			end
		end
	endgenerate
	assign sync_out = out_reg;
endmodule // msq_sync

// *** verilog/msq_top.v ***
// Device mode sequencer with comparator inputs and an AXI4-Lite slave.
`timescale 1ns/100ps
`include "msq_regs.vh"
// Summary of operation
// - Monitor on: buck, and enable or hold.
// - Pull monitor low: prog low, fixed high.
// - Release monitor when prog input rises.
// - Boost: monitor off, pins reused.
// - Dual phase: phase B enable gates both.
// - Dual phase: phase C enable adds phase.
// - Dual: tie phase C, no power good.
// - Overtemperature stops channels, supplies and oscillator (monitor stays on), restarts when cool.
// - All inputs low means full shutdown.
// - Capture straps once before active operation.
// - Reconfigure only after shutdown or supply loss.
// - Active after config; boost runs charge pump.
// - Sixteen skipped cycles put buck asleep.
// - Deep sleep when all asleep and sensed.
// - Deep sleep opens the leakage cut switch.
// - Hold keeps supplies, monitor, fast restart.
// - Overload guard only while channel active.
module msq_top #(
	parameter CFG_CYCLES = `MSQ_CFG_CYC
) (
	input  wire                  ref_clk,
	input  wire                  srst,
	input  wire                  channel_a_enable,
	input  wire                  phase_b_enable,
	input  wire                  phase_c_enable,
	input  wire                  hold_request,
	input  wire                  therm_over,
	input  wire                  batt_mon_fixed_input,
	input  wire                  batt_mon_prog_input,
	input  wire                  supply_lost,
	input  wire                  strap_boost,
	input  wire                  strap_dual_phase,
	input  wire                  strap_skip_mode,
	input  wire [1:0]            overload_restart_select,
	input  wire [1:0]            strap_vout_sel,
	input  wire [2:0]            hs_skip_evt,
	input  wire [2:0]            hs_switch_evt,
	output wire [2:0]            channel_on,
	output wire                  osc_run,
	output wire                  supply_reg_en,
	output wire                  charge_pump_en,
	output wire                  overload_prot_en,
	output wire [1:0]            overload_mode,
	output wire [1:0]            vout_sel,
	output wire                  phase_c_tied,
	output wire                  phase_c_power_good_en,
	output wire                  batt_mon_en,
	output wire                  batt_mon_output_o,
	output wire                  batt_mon_output_oe,
	input  wire [`MSQ_AW-1:0]    s_axi_awaddr,
	input  wire                  s_axi_awvalid,
	output wire                  s_axi_awready,
	input  wire [`MSQ_DW-1:0]    s_axi_wdata,
	input  wire [3:0]            s_axi_wstrb,
	input  wire                  s_axi_wvalid,
	output wire                  s_axi_wready,
	output wire [1:0]            s_axi_bresp,
	output wire                  s_axi_bvalid,
	input  wire                  s_axi_bready,
	input  wire [`MSQ_AW-1:0]    s_axi_araddr,
	input  wire                  s_axi_arvalid,
	output wire                  s_axi_arready,
	output wire [`MSQ_DW-1:0]    s_axi_rdata,
	output wire [1:0]            s_axi_rresp,
	output wire                  s_axi_rvalid,
	input  wire                  s_axi_rready
);
	localparam [7:0] CFG_LAST = CFG_CYCLES[7:0] - 8'h01;

	// Word address decode shared by the read and write paths.
	function [`MSQ_SEL_W-1:0] sel_of;
		input [`MSQ_AW-1:0] a;
		begin
			case (a)
			`MSQ_OFF_CTRL: sel_of = `MSQ_SEL_CTRL;
			`MSQ_OFF_STAT: sel_of = `MSQ_SEL_STAT;
			`MSQ_OFF_CONF: sel_of = `MSQ_SEL_CONF;
			default:       sel_of = `MSQ_SEL_NONE;
			endcase
		end
	endfunction

	wire [`MSQ_SY_W-1:0] sy;
	wire [2:0]           asleep;
	reg  [`MSQ_ST_W-1:0] mode_reg;
	reg  [`MSQ_ST_W-1:0] mode_next;
	reg  [7:0]           cfg_cnt_reg;
	reg                  cfg_valid_reg;
	reg                  boost_reg;
	reg                  dual_reg;
	reg                  skip_reg;
	reg  [1:0]           ovl_reg;
	reg  [1:0]           vout_reg;
	reg  [`MSQ_CTRL_W-1:0] ctrl_reg;
	reg  [2:0]           ch_on_reg;
	reg                  osc_reg;
	reg                  sup_reg;
	reg                  pump_reg;
	reg                  ovl_en_reg;
	reg                  tie_reg;
	reg                  pg_c_reg;
	reg                  mon_en_reg;
	reg                  pin_o_reg;
	reg                  pin_oe_reg;

	// Every comparator and strap crosses in through the synchroniser.
	msq_sync #(
		.W (`MSQ_SY_W)
	) u_sync (
		.ref_clk  (ref_clk),
		.srst     (srst),
		.async_in ({strap_vout_sel, overload_restart_select,
			strap_skip_mode, strap_dual_phase, strap_boost,
			supply_lost, batt_mon_prog_input, batt_mon_fixed_input,
			therm_over, hold_request, phase_c_enable,
			phase_b_enable, channel_a_enable}),
		.sync_out (sy)
	);

	wire en_a    = sy[0];
	wire en_b    = sy[1];
	wire en_c    = sy[2];
	wire hold_s  = sy[3];
	wire hot_s   = sy[4];
	wire fix_s   = sy[5];
	wire prg_s   = sy[6];
	wire lost_s  = sy[7];
	wire [6:0] straps = sy[14:8];
	wire any_en  = en_a | en_b | en_c;
	wire any_req = any_en | hold_s;
	wire run_md  = (mode_reg == `MSQ_ST_ACT) ||
		(mode_reg == `MSQ_ST_DEEP);

	// Channel enables; in dual phase B is the master of both phases.
	wire [2:0] ch_req;
	assign ch_req[0] = en_a;
	assign ch_req[1] = en_b;
	assign ch_req[2] = dual_reg ? (en_b & en_c) : en_c;

	// Sleep tracking only applies to buck channels in skip mode.
	wire [2:0] is_buck = {2'b11, ~boost_reg};
	genvar c;
	generate
		for (c = 0; c < 3; c = c + 1) begin : g_ch
			msq_skip_cnt u_skip (
				.ref_clk  (ref_clk),
				.srst     (srst),
				.allow    (skip_reg & is_buck[c] & ch_req[c] & run_md),
				.skip_evt (hs_skip_evt[c]),
				.sw_evt   (hs_switch_evt[c]),
				.asleep   (asleep[c])
			);
		end
	endgenerate

	// Deep sleep needs every enabled channel asleep; in boost the
	// threshold and drain sense comparators must also agree. Buck
	// parts use those pins for the battery monitor, so skip them.
	wire all_sleep = &(asleep | ~ch_req);
	wire sense_ok  = boost_reg ? (prg_s & fix_s) : 1'b1;
	wire deep_ok   = all_sleep & any_en & sense_ok &
		ctrl_reg[`MSQ_CTRL_DEEP];
	wire ch_active = |(ch_req & ~asleep);
	// Monitor allow term, shared so on a buck part the pin never outlives the enable.
	wire mon_on    = cfg_valid_reg & ~boost_reg & any_req &
		ctrl_reg[`MSQ_CTRL_MON];

	// Mode sequencing; overtemperature overrides every state.
	always @* begin
		mode_next = mode_reg;
		case (mode_reg)
		`MSQ_ST_SHUT: begin
			if (any_req)
				mode_next = `MSQ_ST_CFG;
		end
		`MSQ_ST_CFG: begin
			if (!any_req)
				mode_next = `MSQ_ST_SHUT;
			else if (cfg_cnt_reg == CFG_LAST)
				mode_next = any_en ? `MSQ_ST_ACT : `MSQ_ST_HOLD;
		end
		`MSQ_ST_ACT: begin
			if (!any_en)
				mode_next = hold_s ? `MSQ_ST_HOLD : `MSQ_ST_SHUT;
			else if (deep_ok)
				mode_next = `MSQ_ST_DEEP;
		end
		`MSQ_ST_DEEP: begin
			if (!deep_ok)
				mode_next = `MSQ_ST_ACT;
		end
		`MSQ_ST_HOLD: begin
			if (any_en)
				mode_next = `MSQ_ST_ACT;
			else if (!hold_s)
				mode_next = `MSQ_ST_SHUT;
		end
		`MSQ_ST_THERM: begin
			if (!hot_s)
				mode_next = `MSQ_ST_SHUT;
		end
		default: mode_next = `MSQ_ST_SHUT;
		endcase
		// A discharged supply forgets everything, so restart from scratch.
		if (lost_s)
			mode_next = `MSQ_ST_SHUT;
		if (hot_s)
			mode_next = `MSQ_ST_THERM;
	end

	always @(posedge ref_clk) begin
		if (srst) begin
			mode_reg    <= `MSQ_ST_SHUT;
			cfg_cnt_reg <= 8'h00;
		end else begin
			mode_reg <= mode_next;
			if (mode_reg == `MSQ_ST_CFG)
				cfg_cnt_reg <= cfg_cnt_reg + 8'h01;
			else
				cfg_cnt_reg <= 8'h00;
		end
	end

	// Straps are latched once at the end of configuration and then
	// frozen; only shutdown or a lost supply forgets them, which
	// keeps a glitching strap from retargeting a live converter.
	always @(posedge ref_clk) begin
		if (srst) begin
			cfg_valid_reg <= 1'b0;
			boost_reg     <= 1'b0;
			dual_reg      <= 1'b0;
			skip_reg      <= 1'b0;
			ovl_reg       <= 2'h0;
			vout_reg      <= 2'h0;
		end else if (mode_reg == `MSQ_ST_SHUT || lost_s) begin
			cfg_valid_reg <= 1'b0;
		end else if (mode_reg == `MSQ_ST_CFG &&
			cfg_cnt_reg == CFG_LAST && !cfg_valid_reg) begin
			cfg_valid_reg <= 1'b1;
			{vout_reg, ovl_reg, skip_reg, dual_reg, boost_reg} <= straps;
		end
	end

	// Output stage: every pin-facing signal is a flip-flop.
	always @(posedge ref_clk) begin
		if (srst) begin
			ch_on_reg  <= 3'h0;
			osc_reg    <= 1'b0;
			sup_reg    <= 1'b0;
			pump_reg   <= 1'b0;
			ovl_en_reg <= 1'b0;
			tie_reg    <= 1'b0;
			pg_c_reg   <= 1'b0;
			mon_en_reg <= 1'b0;
			pin_o_reg  <= 1'b0;
			pin_oe_reg <= 1'b0;
		end else begin
			ch_on_reg  <= run_md ? ch_req : 3'h0;
			osc_reg    <= (mode_reg != `MSQ_ST_DEEP) &&
				(mode_reg != `MSQ_ST_SHUT) &&
				(mode_reg != `MSQ_ST_THERM);
			sup_reg    <= (mode_reg != `MSQ_ST_SHUT) &&
				(mode_reg != `MSQ_ST_THERM);
			pump_reg   <= (mode_reg == `MSQ_ST_ACT) &&
				boost_reg;
			ovl_en_reg <= (mode_reg == `MSQ_ST_ACT) &&
				ch_active;
			tie_reg    <= cfg_valid_reg & dual_reg;
			pg_c_reg   <= run_md & ~dual_reg & ch_req[2];
			mon_en_reg <= mon_on;
			pin_o_reg  <= 1'b0;
			if (boost_reg)
				// Cut switch grounds the dividers while awake and
				// opens in deep sleep to stop their drain.
				pin_oe_reg <= cfg_valid_reg &&
					(mode_reg == `MSQ_ST_ACT);
			else
				pin_oe_reg <= mon_on & ~prg_s & fix_s;
		end
	end

	// AXI4-Lite write path: address and data may arrive in either
	// order; each is parked until the other shows up.
	reg              awr_reg;
	reg              wr_reg;
	reg              aw_h_reg;
	reg              w_h_reg;
	reg [`MSQ_AW-1:0] aw_a_reg;
	reg [`MSQ_DW-1:0] w_d_reg;
	reg [3:0]        w_s_reg;
	reg              bv_reg;
	reg [1:0]        br_reg;
	reg              aw_h_n;
	reg              w_h_n;
	reg              bv_n;
	wire aw_take = s_axi_awvalid & awr_reg;
	wire w_take  = s_axi_wvalid & wr_reg;
	wire wr_go   = aw_h_reg & w_h_reg & ~bv_reg;

	always @* begin
		aw_h_n = (aw_h_reg | aw_take) & ~wr_go;
		w_h_n  = (w_h_reg | w_take) & ~wr_go;
		bv_n   = (bv_reg & ~s_axi_bready) | wr_go;
	end

	always @(posedge ref_clk) begin
		if (srst) begin
			awr_reg  <= 1'b0;
			wr_reg   <= 1'b0;
			aw_h_reg <= 1'b0;
			w_h_reg  <= 1'b0;
			aw_a_reg <= {`MSQ_AW{1'b0}};
			w_d_reg  <= {`MSQ_DW{1'b0}};
			w_s_reg  <= 4'h0;
			bv_reg   <= 1'b0;
			br_reg   <= `MSQ_RESP_OK;
			ctrl_reg <= `MSQ_CTRL_RST;
		end else begin
			awr_reg  <= ~aw_h_n & ~bv_n;
			wr_reg   <= ~w_h_n & ~bv_n;
			aw_h_reg <= aw_h_n;
			w_h_reg  <= w_h_n;
			bv_reg   <= bv_n;
			if (aw_take)
				aw_a_reg <= s_axi_awaddr;
			if (w_take) begin
				w_d_reg <= s_axi_wdata;
				w_s_reg <= s_axi_wstrb;
			end
			if (wr_go) begin
				// Only the control word is writable; others refuse.
				if (sel_of(aw_a_reg) == `MSQ_SEL_CTRL) begin
					br_reg <= `MSQ_RESP_OK;
					if (w_s_reg[0])
						ctrl_reg <= w_d_reg[`MSQ_CTRL_W-1:0];
				end else begin
					br_reg <= `MSQ_RESP_ERR;
				end
			end
		end
	end

	// Read path: one read in flight, answered on the same edge that captures the address.
	wire [`MSQ_DW-1:0] stat_w = {{(`MSQ_DW - `MSQ_STAT_W){1'b0}},
		ch_active, all_sleep, asleep, ch_req, cfg_valid_reg,
		mode_reg, hold_s, hot_s, prg_s, fix_s};
	wire [`MSQ_DW-1:0] conf_w = {{(`MSQ_DW - `MSQ_CONF_W){1'b0}},
		vout_reg, ovl_reg, skip_reg, dual_reg, boost_reg};
	wire [`MSQ_DW-1:0] ctrl_w = {{(`MSQ_DW - `MSQ_CTRL_W){1'b0}},
		ctrl_reg};
	reg              arr_reg;
	reg              rv_reg;
	reg [`MSQ_DW-1:0] rd_reg;
	reg [1:0]        rr_reg;
	wire ar_take = s_axi_arvalid & arr_reg;
	wire rv_n    = (rv_reg & ~s_axi_rready) | ar_take;

	always @(posedge ref_clk) begin
		if (srst) begin
			arr_reg <= 1'b0;
			rv_reg  <= 1'b0;
			rd_reg  <= {`MSQ_DW{1'b0}};
			rr_reg  <= `MSQ_RESP_OK;
		end else begin
			arr_reg <= ~rv_n;
			rv_reg  <= rv_n;
			if (ar_take) begin
				rr_reg <= `MSQ_RESP_OK;
				case (sel_of(s_axi_araddr))
				`MSQ_SEL_CTRL: rd_reg <= ctrl_w;
				`MSQ_SEL_STAT: rd_reg <= stat_w;
				`MSQ_SEL_CONF: rd_reg <= conf_w;
				default: begin
					rd_reg <= {`MSQ_DW{1'b0}};
					rr_reg <= `MSQ_RESP_ERR;
				end
				endcase
			end
		end
	end

	assign channel_on            = ch_on_reg;
	assign osc_run               = osc_reg;
	assign supply_reg_en         = sup_reg;
	assign charge_pump_en        = pump_reg;
	assign overload_prot_en      = ovl_en_reg;
	assign overload_mode         = ovl_reg;
	assign vout_sel              = vout_reg;
	assign phase_c_tied          = tie_reg;
	assign phase_c_power_good_en = pg_c_reg;
	assign batt_mon_en           = mon_en_reg;
	assign batt_mon_output_o     = pin_o_reg;
	assign batt_mon_output_oe    = pin_oe_reg;
	assign s_axi_awready         = awr_reg;
	assign s_axi_wready          = wr_reg;
	assign s_axi_bresp           = br_reg;
	assign s_axi_bvalid          = bv_reg;
	assign s_axi_arready         = arr_reg;
	assign s_axi_rdata           = rd_reg;
	assign s_axi_rresp           = rr_reg;
	assign s_axi_rvalid          = rv_reg;
endmodule // msq_top
